// ===== rtl/cgp_chan_regs.sv
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`include "cgp_defines.svh"
// Overview of operation
// - Odd gain N times 0.2 dB, gated
// - Even gain N times 0.2 dB, gated
// - Subtract signed odd offset when enabled
// - Subtract signed even offset when enabled
// - Bits 15-12 enable PRBS lanes 5-8
// - Bits 11-9 pick lane 5 pattern
// - Bits 8-6 pick lane 6 pattern
// - Field k applies only with filter on
// - Bit 0 enables the high-pass filter
module cgp_chan_regs (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic chan8OddGainEn,
   output logic [4:0] chan8OddGain,
   output logic chan8OddOffsetEn,
   output logic [9:0] chan8OddOffset,
   output logic chan8EvenGainEn,
   output logic [4:0] chan8EvenGain,
   output logic chan8EvenOffsetEn,
   output logic [9:0] chan8EvenOffset,
   output logic [3:0] lanePrbsEnable,
   output cgp_pkg::cgp_pat_t lane5PatternCode,
   output cgp_pkg::cgp_pat_t lane6PatternCode,
   output logic lane5PatternEn,
   output logic lane6PatternEn,
   output logic highpassEnable,
   output logic [3:0] highpassK,
   output logic highpassKValid
);
   import cgp_pkg::*;

   // ==========================================
   // Bus decode
   cgp_sel_e sel;
   logic isCtrl;
   logic wrAccess;
   logic lowLanes;
   cgp_word_t oddVal;
   cgp_word_t evenVal;
   cgp_word_t patVal;
   cgp_word_t wdata16;
   logic [2:0] ctrl_reg;
   logic [2:0] ctrl_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic [3:0] kVal;

   function automatic cgp_sel_e decode(input logic [11:0] a);
      cgp_sel_e s;
      s = CGP_SEL_NONE;
      if (a == `CGP_ADDR_ODD) begin
         s = CGP_SEL_ODD;
      end else if (a == `CGP_ADDR_EVEN) begin
         s = CGP_SEL_EVEN;
      end else if (a == `CGP_ADDR_PAT) begin
         s = CGP_SEL_PAT;
      end
      return s;
   endfunction : decode

   // Byte lanes merge with the current value so a partial write leaves other bits intact.
   function automatic cgp_word_t merge(input cgp_word_t old, input logic [15:0] nw,
                                       input logic [1:0] st);
      cgp_word_t r;
      r[7:0] = st[0] ? nw[7:0] : old[7:0];
      r[15:8] = st[1] ? nw[15:8] : old[15:8];
      return r;
   endfunction : merge

   assign sel = decode(paddr);
   assign isCtrl = (paddr == `CGP_ADDR_CTRL);
   assign wrAccess = psel && penable && pwrite;
   // Zero wait states keep the slave simple; every access ends on its first access cycle.
   assign pready = 1'b1;
   assign pslverr = psel && penable && (sel == CGP_SEL_NONE) && !isCtrl;
   assign lowLanes = pstrb[0] || pstrb[1];

   always_comb begin
      unique case (sel)
         CGP_SEL_ODD: wdata16 = merge(oddVal, pwdata[15:0], pstrb[1:0]);
         CGP_SEL_EVEN: wdata16 = merge(evenVal, pwdata[15:0], pstrb[1:0]);
         CGP_SEL_PAT: wdata16 = merge(patVal, pwdata[15:0], pstrb[1:0]);
         CGP_SEL_NONE: wdata16 = `CGP_RESET_VAL;
      endcase
   end

   // ==========================================
   // Register storage
   // reserved bits masked
   cgp_word_reg u_odd (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wrEn(wrAccess && (sel == CGP_SEL_ODD) && lowLanes),
      .wrData(wdata16),
      .wrMask(`CGP_ODD_MASK),
      .value(oddVal)
   );

   cgp_word_reg u_even (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wrEn(wrAccess && (sel == CGP_SEL_EVEN) && lowLanes),
      .wrData(wdata16),
      .wrMask(`CGP_ODD_MASK),
      .value(evenVal)
   );

   cgp_word_reg u_pat (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wrEn(wrAccess && (sel == CGP_SEL_PAT) && lowLanes),
      .wrData(wdata16),
      .wrMask(`CGP_PAT_MASK),
      .value(patVal)
   );

   // Global gain, offset and pattern enables (one bit shared by lanes 5 and 6) live elsewhere in the
   // device; they are mirrored here so this slice can gate its own outputs.
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wrAccess && isCtrl && pstrb[0]) begin
         ctrl_next = pwdata[2:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= 3'h0;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ==========================================
   // Read data
   always_comb begin
      prdata_next = prdata_reg;
      if (psel && !penable && !pwrite) begin
         prdata_next = 32'h0000_0000;
         unique case (sel)
            CGP_SEL_ODD: prdata_next = {16'h0000, oddVal};
            CGP_SEL_EVEN: prdata_next = {16'h0000, evenVal};
            CGP_SEL_PAT: prdata_next = {16'h0000, patVal};
            CGP_SEL_NONE: prdata_next = isCtrl ? {29'h0000_0000, ctrl_reg} : 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_reg <= 32'h0000_0000;
      end else begin
         prdata_reg <= prdata_next;
      end
   end
   assign prdata = prdata_reg;

   // ==========================================
   // Datapath controls
   // odd gain gated
   assign chan8OddGainEn = ctrl_reg[`CGP_CTRL_GAIN_BIT];
   assign chan8OddGain = oddVal[`CGP_GAIN_MSB:`CGP_GAIN_LSB];
   assign chan8EvenGainEn = ctrl_reg[`CGP_CTRL_GAIN_BIT];
   assign chan8EvenGain = evenVal[`CGP_GAIN_MSB:`CGP_GAIN_LSB];
   assign chan8OddOffsetEn = ctrl_reg[`CGP_CTRL_OFS_BIT];
   assign chan8OddOffset = oddVal[`CGP_OFS_MSB:`CGP_OFS_LSB];
   assign chan8EvenOffsetEn = ctrl_reg[`CGP_CTRL_OFS_BIT];
   assign chan8EvenOffset = evenVal[`CGP_OFS_MSB:`CGP_OFS_LSB];
   assign lanePrbsEnable = ctrl_reg[`CGP_CTRL_PAT_BIT] ?
                           patVal[`CGP_PRBS5_BIT:`CGP_PRBS8_BIT] : 4'h0;
   assign lane5PatternEn = ctrl_reg[`CGP_CTRL_PAT_BIT];
   assign lane5PatternCode = patVal[`CGP_PAT5_MSB:`CGP_PAT5_LSB];
   assign lane6PatternEn = ctrl_reg[`CGP_CTRL_PAT_BIT];
   assign lane6PatternCode = patVal[`CGP_PAT6_MSB:`CGP_PAT6_LSB];
   assign highpassEnable = patVal[`CGP_HPF_BIT];
   assign kVal = patVal[`CGP_K_MSB:`CGP_K_LSB];
   assign highpassK = highpassEnable ? kVal : 4'h0;
   assign highpassKValid = highpassEnable && (kVal >= `CGP_K_MIN) && (kVal <= `CGP_K_MAX);
endmodule : cgp_chan_regs

// ===== rtl/cgp_defines.svh
`ifndef CGP_DEFINES_SVH
`define CGP_DEFINES_SVH

// ==========================================
// Register byte addresses (index times four)
`define CGP_IDX_ODD 8'h1F
`define CGP_IDX_EVEN 8'h20
`define CGP_IDX_PAT 8'h21
`define CGP_ADDR_ODD 12'h07C
`define CGP_ADDR_EVEN 12'h080
`define CGP_ADDR_PAT 12'h084
`define CGP_ADDR_CTRL 12'h100

// ==========================================
// Field positions
`define CGP_GAIN_MSB 15
`define CGP_GAIN_LSB 11
`define CGP_OFS_MSB 9
`define CGP_OFS_LSB 0
`define CGP_PRBS5_BIT 15
`define CGP_PRBS8_BIT 12
`define CGP_PAT5_MSB 11
`define CGP_PAT5_LSB 9
`define CGP_PAT6_MSB 8
`define CGP_PAT6_LSB 6
`define CGP_K_MSB 4
`define CGP_K_LSB 1
`define CGP_HPF_BIT 0
`define CGP_CTRL_GAIN_BIT 0
`define CGP_CTRL_OFS_BIT 1
`define CGP_CTRL_PAT_BIT 2

// ==========================================
// Reset values and limits
`define CGP_RESET_VAL 16'h0000
`define CGP_ODD_MASK 16'hFBFF
`define CGP_PAT_MASK 16'hFFDF
`define CGP_K_MIN 4'h2
`define CGP_K_MAX 4'hA

`endif

// ===== rtl/cgp_pkg.sv
package cgp_pkg;
   typedef logic [15:0] cgp_word_t;
   typedef logic [2:0] cgp_pat_t;
   typedef enum logic [1:0] {CGP_SEL_NONE, CGP_SEL_ODD, CGP_SEL_EVEN, CGP_SEL_PAT} cgp_sel_e;
endpackage : cgp_pkg

// ===== rtl/cgp_word_reg.sv
`timescale 1ns/10ps
`include "cgp_defines.svh"
module cgp_word_reg (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic wrEn,
   input wire cgp_pkg::cgp_word_t wrData,
   input wire cgp_pkg::cgp_word_t wrMask,
   output cgp_pkg::cgp_word_t value
);
   import cgp_pkg::*;
   cgp_word_t value_reg;
   // ==========================================
   // Storage
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         value_reg <= `CGP_RESET_VAL;
      end else if (wrEn) begin
         value_reg <= wrData & wrMask;
      end
   end
   assign value = value_reg;
endmodule : cgp_word_reg

// ===== verification/cgp_chan_regs_props.sv
`timescale 1ns/10ps
// ==========================================
// Port checks for the channel 8 register slice.
module cgp_chan_regs_chk (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic [4:0] chan8OddGain,
   input wire logic [9:0] chan8OddOffset,
   input wire logic [9:0] chan8EvenOffset,
   input wire logic [3:0] lanePrbsEnable,
   input wire logic lane5PatternEn,
   input wire logic lane6PatternEn,
   input wire logic highpassEnable,
   input wire logic [3:0] highpassK,
   input wire logic highpassKValid
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire wrEv = psel && penable && pwrite && pready;
   wire [4:0] wGain = pwdata[15:11];
   wire [9:0] wOfs = pwdata[9:0];
   a_odd_gain: assert property (wrEv && paddr == 12'h07C && pstrb[1]
      |=> chan8OddGain == $past(wGain)) else $error("odd gain not stored");
   a_odd_offset: assert property (wrEv && paddr == 12'h07C && pstrb[1:0] == 2'b11
      |=> chan8OddOffset == $past(wOfs)) else $error("odd offset not stored");
   a_even_offset: assert property (wrEv && paddr == 12'h080 && pstrb[1:0] == 2'b11
      |=> chan8EvenOffset == $past(wOfs)) else $error("even offset not stored");
   a_even_hold: assert property (!wrEv |=> $stable(chan8EvenOffset))
      else $error("even offset moved without write");
   a_prbs_gate: assert property (!lane5PatternEn |-> lanePrbsEnable == 4'h0)
      else $error("prbs enabled without pattern select");
   a_pattern_tie: assert property (lane5PatternEn == lane6PatternEn)
      else $error("pattern enables differ");
   a_k_valid: assert property (highpassKValid == (highpassEnable && highpassK >= 4'h2
      && highpassK <= 4'hA)) else $error("k valid flag wrong");
   a_k_gate: assert property (!highpassEnable |-> highpassK == 4'h0)
      else $error("k shown with filter off");
   a_hpf_write: assert property (wrEv && paddr == 12'h084 && pstrb[0]
      |=> highpassEnable == $past(pwdata[0])) else $error("filter enable not stored");
endmodule : cgp_chan_regs_chk

bind cgp_chan_regs cgp_chan_regs_chk cgp_chan_regs_chk_i (.*);

// ===== verification/test_cgp_chan_regs.sv
`timescale 1ns/10ps
// ==========================================
// Register bench driven over the APB port.
module test_cgp_chan_regs;
   logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic [3:0] pstrb = 4'hF, lanePrbsEnable, highpassK;
   logic pready, pslverr, err, chan8OddGainEn, chan8OddOffsetEn, chan8EvenGainEn;
   logic chan8EvenOffsetEn, lane5PatternEn, lane6PatternEn, highpassEnable, highpassKValid;
   logic [4:0] chan8OddGain, chan8EvenGain;
   logic [9:0] chan8OddOffset, chan8EvenOffset;
   cgp_pkg::cgp_pat_t lane5PatternCode, lane6PatternCode;
   int fails = 0, checked = 0;
   always #12.5 sys_clk = ~sys_clk;
   cgp_chan_regs cgp_chan_regs_i (.*);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One idle edge after the access lets the write land before outputs are looked at.
   task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   initial begin
      repeat (3000) @(posedge sys_clk);
      fails++;
      $display("ERROR %0t timeout", $time);
      stop_test();
   end
   initial begin
      logic [2:0] c, cn;
      logic [3:0] k;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      apb(1'b0, 12'h07C, 16'h0000); chk(rd, 32'h0);
      apb(1'b0, 12'h080, 16'h0000); chk(rd, 32'h0);
      apb(1'b0, 12'h084, 16'h0000); chk(rd, 32'h0);
      $display("test reset done");
      apb(1'b1, 12'h100, 16'h0007);
      apb(1'b1, 12'h07C, 16'hFFFF);
      chk({chan8OddGainEn, chan8OddGain}, {1'b1, 5'h1F});
      chk({chan8OddOffsetEn, chan8OddOffset}, {1'b1, 10'h3FF});
      apb(1'b0, 12'h07C, 16'h0000); chk(rd, 32'h0000FBFF);
      apb(1'b1, 12'h080, 16'h5A05);
      chk({chan8EvenGainEn, chan8EvenGain}, {1'b1, 5'h0B});
      chk({chan8EvenOffsetEn, chan8EvenOffset}, {1'b1, 10'h205});
      chk(chan8OddOffset, 10'h3FF);
      $display("test gain offset done");
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         cn = ~c;
         apb(1'b1, 12'h084, {4'hA, c, cn, 1'b0, 4'h5, 1'b1});
         chk({lanePrbsEnable, lane5PatternCode}, {4'hA, c});
         chk(lane6PatternCode, cn);
      end
      for (int i = 0; i < 16; i++) begin
         k = 4'(i);
         apb(1'b1, 12'h084, {11'h000, k, 1'b1});
         chk({highpassK, highpassKValid}, {k, k >= 4'h2 && k <= 4'hA});
      end
      apb(1'b1, 12'h084, 16'h000A);
      chk({highpassEnable, highpassK, highpassKValid}, 6'h00);
      apb(1'b1, 12'h084, 16'hFFFF);
      apb(1'b0, 12'h084, 16'h0000); chk(rd, 32'h0000FFDF);
      apb(1'b1, 12'h100, 16'h0000);
      chk({lanePrbsEnable, lane5PatternEn, chan8OddGainEn}, 6'h00);
      $display("test pattern filter done");
      apb(1'b1, 12'h0F0, 16'h1234); chk(err, 1'b1);
      apb(1'b0, 12'h0F0, 16'h0000); chk({err, rd}, {1'b1, 32'h0});
      $display("test unmapped done");
      stop_test();
   end
endmodule : test_cgp_chan_regs
